// ### hw/wwdm_pkg.sv
// Package for the windowed watchdog mode configuration block
// Assumes a single 8-bit mode register reached over a plain strobe port
`default_nettype none
package wwdm_pkg;
  localparam logic [31:0] MODE_ADDR = 32'h4000070c;
  localparam logic [7:0] MODE_RESET = 8'h0f;
  localparam logic [7:0] MODE_RMASK = 8'h77;
  localparam int OVF_LSB = 4;
  localparam int ERM_BIT = 2;
  localparam int WS_LSB = 0;
  localparam int OVF_EXP_BASE = 9;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  typedef enum logic [1:0] {WWDM_OPEN, WWDM_LOCKED, WWDM_RUNNING} wwdm_phase_t;
endpackage : wwdm_pkg
`default_nettype wire

// ### hw/wwdm_decode.sv
// Decodes the pending mode value into interval and window lengths in count-clock periods
// Assumes a mode byte already registered in the same clock domain
`default_nettype none
module wwdm_decode (
  input wire logic [7:0] mode,
  output logic [16:0] interval_len,
  output logic [16:0] window_len,
  output logic reset_action
);
  logic [2:0] ovf;
  logic [1:0] ws;
  logic [18:0] prod;

  assign ovf = mode[wwdm_pkg::OVF_LSB +: 3];
  assign ws = mode[wwdm_pkg::WS_LSB +: 2];
  assign interval_len = 17'(17'h00001 << (wwdm_pkg::OVF_EXP_BASE + int'(ovf)));
  // Quarter steps of the interval: 25, 50, 75, 100 percent
  assign prod = 19'(interval_len) * 19'({1'b0, ws} + 3'h1);
  assign window_len = prod[18:2];
  assign reset_action = mode[wwdm_pkg::ERM_BIT];
endmodule : wwdm_decode
`default_nettype wire

// ### hw/wwdm_top.sv
// Mode configuration front end of a windowed watchdog
// Assumes a counting core that supplies a one-cycle trigger pulse on ref_clk
//
// Implementation choice: the address-and-strobe port.
`default_nettype none
module wwdm_top (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [31:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic wdt_trigger,
  output logic [16:0] interval_len,
  output logic [16:0] window_len,
  output logic err_nmi,
  output logic err_reset,
  output logic mode_error
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    wwdm_pkg::wwdm_phase_t phase;
    logic [7:0] pend;
    logic [7:0] act;
    logic [7:0] rdata;
    logic [16:0] ilen;
    logic [16:0] wlen;
    logic nmi;
    logic rst;
    logic err;
  } wwdm_state_t;

  wwdm_state_t st_r;
  wwdm_state_t st_nxt;
  logic [16:0] dec_ilen;
  logic [16:0] dec_wlen;
  logic dec_rst;
  logic hit;
  logic bad_write;

  // Decode from the pending value: it becomes active on the next trigger
  wwdm_decode u_dec (
    .mode(st_r.pend),
    .interval_len(dec_ilen),
    .window_len(dec_wlen),
    .reset_action(dec_rst)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    hit = 1'b0;
    bad_write = 1'b0;
    st_nxt.nmi = 1'b0;
    st_nxt.rst = 1'b0;
    st_nxt.err = 1'b0;
    if (addr == wwdm_pkg::MODE_ADDR) begin
      hit = 1'b1;
    end
    if (rd_stb) begin
      if (hit) begin
        st_nxt.rdata = st_r.pend & wwdm_pkg::MODE_RMASK;
      end else begin
        st_nxt.rdata = wwdm_pkg::UNMAPPED_RD;
      end
    end
    if (wr_stb && hit) begin
      case (st_r.phase)
        wwdm_pkg::WWDM_OPEN: begin
          st_nxt.pend = wdata & wwdm_pkg::MODE_RMASK;
          st_nxt.phase = wwdm_pkg::WWDM_LOCKED;
        end
        default: begin
          // Further writes never change the value; only a mismatch after start errs
          if (st_r.phase == wwdm_pkg::WWDM_RUNNING &&
              (wdata & wwdm_pkg::MODE_RMASK) != st_r.pend) begin
            bad_write = 1'b1;
          end
        end
      endcase
    end
    if (wdt_trigger) begin
      st_nxt.act = st_r.pend;
      st_nxt.ilen = dec_ilen;
      st_nxt.wlen = dec_wlen;
      st_nxt.phase = wwdm_pkg::WWDM_RUNNING;
    end
    if (bad_write) begin
      st_nxt.err = 1'b1;
      st_nxt.rst = st_r.act[wwdm_pkg::ERM_BIT];
      st_nxt.nmi = ~st_r.act[wwdm_pkg::ERM_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_r <= '{phase: wwdm_pkg::WWDM_OPEN, pend: wwdm_pkg::MODE_RESET,
                act: wwdm_pkg::MODE_RESET, rdata: 8'h00,
                ilen: 17'h10000, wlen: 17'h10000,
                nmi: 1'b0, rst: 1'b0, err: 1'b0};
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign interval_len = st_r.ilen;
  assign window_len = st_r.wlen;
  assign err_nmi = st_r.nmi;
  assign err_reset = st_r.rst;
  assign mode_error = st_r.err;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_diff_write;
    clk_en && wr_stb && hit && st_r.phase == wwdm_pkg::WWDM_RUNNING &&
      (wdata & wwdm_pkg::MODE_RMASK) != st_r.pend;
  endsequence

  sequence s_same_write;
    clk_en && wr_stb && hit && (wdata & wwdm_pkg::MODE_RMASK) == st_r.pend;
  endsequence

  sequence s_trig;
    clk_en && wdt_trigger;
  endsequence

  sequence s_open_write;
    clk_en && wr_stb && hit && st_r.phase == wwdm_pkg::WWDM_OPEN && !wdt_trigger;
  endsequence

  sequence s_no_write;
    clk_en && !(wr_stb && hit);
  endsequence

  property p_one_update;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && wr_stb && hit && st_r.phase != wwdm_pkg::WWDM_OPEN) |=> $stable(st_r.pend);
  endproperty
  a_one_update: assert property (p_one_update) else $error("mode changed twice");

  property p_first_write;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && wr_stb && hit && st_r.phase == wwdm_pkg::WWDM_OPEN) |=>
        st_r.pend == ($past(wdata) & wwdm_pkg::MODE_RMASK);
  endproperty
  a_first_write: assert property (p_first_write) else $error("first write lost");

  property p_no_early_effect;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && !wdt_trigger) |=> $stable(st_r.act) && $stable(interval_len);
  endproperty
  a_no_early_effect: assert property (p_no_early_effect) else $error("mode early");

  property p_trigger_applies;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && wdt_trigger) |=> st_r.act == $past(st_r.pend);
  endproperty
  a_trigger_applies: assert property (p_trigger_applies) else $error("trigger ignored");

  property p_diff_errs;
    @(posedge ref_clk) disable iff (!reset_n)
      s_diff_write |=> mode_error ##1 (!mode_error || $past(bad_write));
  endproperty
  a_diff_errs: assert property (p_diff_errs) else $error("missing error");

  property p_same_quiet;
    @(posedge ref_clk) disable iff (!reset_n)
      s_same_write |=> !mode_error;
  endproperty
  a_same_quiet: assert property (p_same_quiet) else $error("spurious error");

  property p_read_byte;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && rd_stb && hit) |=> rdata == ($past(st_r.pend) & wwdm_pkg::MODE_RMASK);
  endproperty
  a_read_byte: assert property (p_read_byte) else $error("bad read data");

  property p_action;
    @(posedge ref_clk) disable iff (!reset_n)
      mode_error |-> (err_reset == $past(st_r.act[wwdm_pkg::ERM_BIT])) &&
        (err_nmi != err_reset);
  endproperty
  a_action: assert property (p_action) else $error("wrong error action");

  property p_interval;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && wdt_trigger) |=>
        interval_len == 17'(17'h00001 << (wwdm_pkg::OVF_EXP_BASE +
          int'($past(st_r.pend[wwdm_pkg::OVF_LSB +: 3]))));
  endproperty
  a_interval: assert property (p_interval) else $error("bad interval");

  property p_window;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && wdt_trigger) |=>
        window_len == 17'(32'(interval_len >> 2) *
          (int'(st_r.act[wwdm_pkg::WS_LSB +: 2]) + 1));
  endproperty
  a_window: assert property (p_window) else $error("bad window");

  ////////////////////////////////////////////////////////////////////////////
  // Lock, start and freeze of the mode state
  property p_lock_phase;
    @(posedge ref_clk) disable iff (!reset_n)
      s_open_write |=> st_r.phase == wwdm_pkg::WWDM_LOCKED;
  endproperty
  a_lock_phase: assert property (p_lock_phase) else $error("not locked");

  property p_started;
    @(posedge ref_clk) disable iff (!reset_n)
      s_trig |=> st_r.phase == wwdm_pkg::WWDM_RUNNING;
  endproperty
  a_started: assert property (p_started) else $error("not started");

  property p_running_sticky;
    @(posedge ref_clk) disable iff (!reset_n)
      st_r.phase == wwdm_pkg::WWDM_RUNNING |=> st_r.phase == wwdm_pkg::WWDM_RUNNING;
  endproperty
  a_running_sticky: assert property (p_running_sticky) else $error("left running");

  property p_pend_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && !(wr_stb && hit && st_r.phase == wwdm_pkg::WWDM_OPEN)) |=>
        $stable(st_r.pend);
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("mode value moved");

  property p_same_keeps;
    @(posedge ref_clk) disable iff (!reset_n)
      s_same_write |=> $stable(st_r.pend);
  endproperty
  a_same_keeps: assert property (p_same_keeps) else $error("same value moved");

  // A low clock enable holds every field, outputs included
  property p_freeze;
    @(posedge ref_clk) disable iff (!reset_n)
      !clk_en |=> $stable(st_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  ////////////////////////////////////////////////////////////////////////////
  // Error reporting
  property p_locked_quiet;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && wr_stb && hit && st_r.phase != wwdm_pkg::WWDM_RUNNING) |=>
        !mode_error;
  endproperty
  a_locked_quiet: assert property (p_locked_quiet) else $error("error before start");

  property p_no_stray_err;
    @(posedge ref_clk) disable iff (!reset_n)
      s_no_write |=> !mode_error;
  endproperty
  a_no_stray_err: assert property (p_no_stray_err) else $error("error without write");

  property p_err_quiet;
    @(posedge ref_clk) disable iff (!reset_n)
      !mode_error |-> !err_nmi && !err_reset;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("action without error");

  property p_action_latch;
    @(posedge ref_clk) disable iff (!reset_n)
      s_trig |=> st_r.act[wwdm_pkg::ERM_BIT] == $past(dec_rst);
  endproperty
  a_action_latch: assert property (p_action_latch) else $error("action not taken");

  ////////////////////////////////////////////////////////////////////////////
  // Read port and active lengths
  property p_unmapped_read;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && rd_stb && !hit) |=> rdata == wwdm_pkg::UNMAPPED_RD;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (!reset_n)
      (rdata & ~wwdm_pkg::MODE_RMASK) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_read_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && !rd_stb) |=> $stable(rdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved");

  property p_window_bound;
    @(posedge ref_clk) disable iff (!reset_n)
      window_len <= interval_len;
  endproperty
  a_window_bound: assert property (p_window_bound) else $error("window too long");

  property p_lengths_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && !wdt_trigger) |=> $stable(window_len);
  endproperty
  a_lengths_hold: assert property (p_lengths_hold) else $error("window early");

endmodule : wwdm_top
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the windowed watchdog mode configuration block
// Assumes wwdm_top alone, one clock, register port driven by the bench
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic wdt_trigger = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] rdata;
  logic [16:0] interval_len;
  logic [16:0] window_len;
  logic err_nmi;
  logic err_reset;
  logic mode_error;
  int miscompares = 0;
  int checked = 0;
  logic [7:0] m;
  logic [16:0] ivl;
  always #12.5 ref_clk = ~ref_clk;
  wwdm_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .wdt_trigger(wdt_trigger), .interval_len(interval_len), .window_len(window_len),
    .err_nmi(err_nmi), .err_reset(err_reset), .mode_error(mode_error));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic chk_data(input string n, input logic [16:0] exp, input logic [16:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask : chk_data
  task automatic chk_flag(input string n, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", n, exp, got);
    end
  endtask : chk_flag
  task automatic do_reset;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask : do_reset
  task automatic reg_wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [31:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd
  task automatic trig;
    @(posedge ref_clk);
    wdt_trigger <= 1'b1;
    @(posedge ref_clk);
    wdt_trigger <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : trig
  // Watches three cycles after a write for the error pulse and its action
  task automatic err_watch(input logic exp_err, input logic exp_rst);
    logic seen;
    logic rst;
    logic nmi;
    seen = 1'b0;
    rst = 1'b0;
    nmi = 1'b0;
    repeat (3) begin
      #1;
      if (mode_error === 1'b1) begin
        seen = 1'b1;
        rst = err_reset;
        nmi = err_nmi;
      end
      @(posedge ref_clk);
    end
    chk_flag("mode_error", exp_err, seen);
    if (exp_err) begin
      chk_flag("err_reset", exp_rst, rst);
      chk_flag("err_nmi", ~exp_rst, nmi);
    end
  endtask : err_watch
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    miscompares++;
    complete_run();
  end
  initial begin
    do_reset();
    reg_rd(wwdm_pkg::MODE_ADDR, m);
    chk_data("reset mode", 17'h00007, {9'h000, m});
    // A write taken while the clock enable is low must leave the update unused
    @(posedge ref_clk);
    clk_en <= 1'b0;
    reg_wr(wwdm_pkg::MODE_ADDR, 8'h11);
    clk_en <= 1'b1;
    reg_rd(wwdm_pkg::MODE_ADDR, m);
    chk_data("frozen write", 17'h00007, {9'h000, m});
    reg_wr(wwdm_pkg::MODE_ADDR, 8'ha5);
    reg_wr(wwdm_pkg::MODE_ADDR, 8'h36);
    err_watch(1'b0, 1'b0);
    reg_rd(wwdm_pkg::MODE_ADDR, m);
    chk_data("mode after second write", 17'h00025, {9'h000, m});
    chk_data("interval before trigger", 17'h10000, interval_len);
    reg_rd(32'h40000710, m);
    chk_data("unmapped read", 17'h00000, {9'h000, m});
    trig();
    chk_data("interval", 17'h00800, interval_len);
    chk_data("window", 17'h00400, window_len);
    reg_wr(wwdm_pkg::MODE_ADDR, 8'h25);
    err_watch(1'b0, 1'b0);
    reg_wr(wwdm_pkg::MODE_ADDR, 8'h2d);
    err_watch(1'b0, 1'b0);
    reg_wr(wwdm_pkg::MODE_ADDR, 8'h26);
    err_watch(1'b1, 1'b1);
    reg_rd(wwdm_pkg::MODE_ADDR, m);
    chk_data("mode after error", 17'h00025, {9'h000, m});
    for (int i = 0; i < 8; i++) begin
      do_reset();
      m = {1'b0, 3'(i), 1'b0, 1'(i), 2'(i)};
      reg_wr(wwdm_pkg::MODE_ADDR, m);
      trig();
      ivl = 17'h00001 << (9 + i);
      chk_data("interval code", ivl, interval_len);
      chk_data("window code", 17'((ivl >> 2) * (i % 4 + 1)), window_len);
      reg_wr(wwdm_pkg::MODE_ADDR, m ^ 8'h40);
      err_watch(1'b1, 1'(i));
    end
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
